// [design/spi_link_cfg.svh]
// Constants shared by both ends of the host serial link
`ifndef SPI_LINK_CFG_SVH
`define SPI_LINK_CFG_SVH

// System clock period in ns
`define SPI_CLK_PERIOD_NS 10
// Least half period of the serial clock in ns
`define SPI_SCK_HALF_NS 40
// Half period in system cycles, rounded up
`define SPI_SCK_HALF_CYC ((`SPI_SCK_HALF_NS + `SPI_CLK_PERIOD_NS - 1) / `SPI_CLK_PERIOD_NS)
// Bits in one serial word
`define SPI_WORD_BITS 8
// Index of the last bit of a word
`define SPI_LAST_BIT 3'h7
// Byte sent by the reader when it has nothing to say
`define SPI_FILL_BYTE 8'h00
// Depth of the command buffer in the reader
`define SPI_BUF_DEPTH 2

`endif

// [design/spi_link_pkg.sv]
// Types and helpers shared by both ends of the host serial link
package spi_link_pkg;

  // Host sequencer states
  typedef enum logic [2:0] {
    H_IDLE,
    H_LEAD,
    H_HIGH,
    H_LOW,
    H_WAIT,
    H_GAP
  } host_state_t;

  // One received command byte with its start-of-message mark
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } cmd_word_t;

  // Shift a word one place towards its top bit
  function automatic logic [7:0] shift_up(input logic [7:0] w, input logic b);
    return {w[6:0], b};
  endfunction : shift_up

endpackage : spi_link_pkg

// [design/spi_link_if.sv]
// Wires between the host end and the reader end of the serial link
`timescale 1ns/100ps
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic boot_sel_n;
  logic dev_miso;
  logic dev_miso_oe;
  logic miso;

  // Line level seen by the host; reads low while the reader is off the line
  assign miso = dev_miso_oe ? dev_miso : 1'b0;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    input boot_sel_n,
    output dev_miso,
    output dev_miso_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    output boot_sel_n,
    input miso
  );
endinterface : spi_link_if

// [design/reader_spi_slave.sv]
// Reader end of the host serial link: slave shifter, command buffer, framing
// Notes on behaviour
// - Reader is slave; host drives clock, select
// - Words are eight bits, top bit first
// - Multi-byte values travel top byte first
// - Host keeps serial clock low when idle
// - Drive on rising edge, sample on falling
// - Host message opens with one identifier byte
// - Reader reply opens with one response code
// - Some commands get no reply at all
// - Boot line low at reset selects update
`timescale 1ns/100ps
`include "spi_link_cfg.svh"
module reader_spi_slave (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  spi_link_if.dev link,
  output logic [7:0] cmd_data_o,
  output logic cmd_first_o,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output logic msg_end_o,
  input wire logic [7:0] rsp_data_i,
  input wire logic rsp_valid_i,
  output logic rsp_ready_o,
  output logic overrun_o,
  output logic boot_update_o
);

  // Serial shifter state
  logic sclk_prev_r, sclk_prev_nxt;
  logic active_r, active_nxt;
  logic first_r, first_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] rx_shift_r, rx_shift_nxt;
  logic [7:0] tx_shift_r, tx_shift_nxt;
  logic miso_r, miso_nxt;
  logic msg_end_r, msg_end_nxt;
  logic overrun_r, overrun_nxt;

  // Command buffer state
  spi_link_pkg::cmd_word_t mem_r [`SPI_BUF_DEPTH];
  spi_link_pkg::cmd_word_t mem_nxt [`SPI_BUF_DEPTH];
  logic wr_ptr_r, wr_ptr_nxt;
  logic rd_ptr_r, rd_ptr_nxt;
  logic [1:0] count_r, count_nxt;

  // Boot strap state
  logic boot_done_r, boot_done_nxt;
  logic boot_upd_r, boot_upd_nxt;

  // Edges of the host clock, seen only while selected
  logic rise;
  logic fall;
  logic selected;
  logic push;
  logic pop;
  logic buf_ready;
  spi_link_pkg::cmd_word_t push_word;

  // Select and clock edge decode; the clock idles low between frames
  assign selected = !link.cs_n;
  assign rise = selected && link.sclk && !sclk_prev_r;
  assign fall = selected && !link.sclk && sclk_prev_r;

  // Buffer handshake terms
  assign buf_ready = (count_r != 2'(`SPI_BUF_DEPTH));
  assign pop = cmd_valid_o && cmd_ready_i;

  // A reply byte is taken at the first rising edge of each word
  assign rsp_ready_o = rise && (bit_cnt_r == 3'h0);

  // Next state of the serial shifter
  always_comb begin
    sclk_prev_nxt = link.sclk;
    active_nxt = active_r;
    first_nxt = first_r;
    bit_cnt_nxt = bit_cnt_r;
    rx_shift_nxt = rx_shift_r;
    tx_shift_nxt = tx_shift_r;
    miso_nxt = miso_r;
    msg_end_nxt = 1'b0;
    overrun_nxt = overrun_r;
    push = 1'b0;
    push_word.first = first_r;
    push_word.data = spi_link_pkg::shift_up(rx_shift_r, link.mosi);
    if (!selected) begin
      // Select released: message closed, next byte is an identifier
      bit_cnt_nxt = 3'h0;
      first_nxt = 1'b1;
      active_nxt = 1'b0;
      msg_end_nxt = active_r;
    end else begin
      if (!active_r) begin
        // New message opens with a clean error flag
        overrun_nxt = 1'b0;
      end
      active_nxt = 1'b1;
      if (rise) begin
        if (bit_cnt_r == 3'h0) begin
          if (rsp_valid_i) begin
            // Reply byte, top bit first
            miso_nxt = rsp_data_i[7];
            tx_shift_nxt = spi_link_pkg::shift_up(rsp_data_i, 1'b0);
          end else begin
            // No reply pending: fill byte goes out instead
            miso_nxt = 1'(`SPI_FILL_BYTE >> 7);
            tx_shift_nxt = spi_link_pkg::shift_up(`SPI_FILL_BYTE, 1'b0);
          end
        end else begin
          miso_nxt = tx_shift_r[7];
          tx_shift_nxt = spi_link_pkg::shift_up(tx_shift_r, 1'b0);
        end
      end
      if (fall) begin
        rx_shift_nxt = spi_link_pkg::shift_up(rx_shift_r, link.mosi);
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        if (bit_cnt_r == `SPI_LAST_BIT) begin
          // Eight bits in: hand the word to the buffer, or flag overrun and drop it when the buffer is full
          first_nxt = 1'b0;
          if (buf_ready) begin
            push = 1'b1;
          end else begin
            overrun_nxt = 1'b1;
          end
        end
      end
    end
  end

  // Register the serial shifter
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev_r <= 1'b0;
      active_r <= 1'b0;
      first_r <= 1'b1;
      bit_cnt_r <= 3'h0;
      rx_shift_r <= 8'h00;
      tx_shift_r <= 8'h00;
      miso_r <= 1'b0;
      msg_end_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_prev_nxt;
      active_r <= active_nxt;
      first_r <= first_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_shift_r <= rx_shift_nxt;
      tx_shift_r <= tx_shift_nxt;
      miso_r <= miso_nxt;
      msg_end_r <= msg_end_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  // Next state of the two-entry command buffer
  always_comb begin
    mem_nxt = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = push_word;
      wr_ptr_nxt = !wr_ptr_r;
    end
    if (pop) begin
      rd_ptr_nxt = !rd_ptr_r;
    end
    case ({push, pop})
      2'b10: count_nxt = count_r + 2'h1;
      2'b01: count_nxt = count_r - 2'h1;
      default: count_nxt = count_r;
    endcase
  end

  // Register the command buffer
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // Catch the boot line once, in the first cycle after reset release
  always_comb begin
    boot_done_nxt = 1'b1;
    boot_upd_nxt = boot_upd_r;
    if (!boot_done_r) begin
      boot_upd_nxt = !link.boot_sel_n;
    end
  end

  // Register the boot strap
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boot_done_r <= 1'b0;
      boot_upd_r <= 1'b0;
    end else begin
      boot_done_r <= boot_done_nxt;
      boot_upd_r <= boot_upd_nxt;
    end
  end

  // Outputs; the data line is driven only while selected
  assign link.dev_miso = miso_r;
  assign link.dev_miso_oe = selected;
  assign cmd_valid_o = (count_r != 2'h0);
  assign cmd_data_o = mem_r[rd_ptr_r].data;
  assign cmd_first_o = mem_r[rd_ptr_r].first;
  assign msg_end_o = msg_end_r;
  assign overrun_o = overrun_r;
  assign boot_update_o = boot_upd_r;

endmodule : reader_spi_slave

// [design/reader_spi_master.sv]
// Host end of the reader serial link: clock divider and byte sequencer
`timescale 1ns/100ps
`include "spi_link_cfg.svh"
module reader_spi_master (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  spi_link_if.host link,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic busy_o,
  input wire logic boot_update_i
);

  spi_link_pkg::host_state_t state_r, state_nxt;
  logic [2:0] div_r, div_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [7:0] rx_data_r, rx_data_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic last_r, last_nxt;
  logic sclk_r, sclk_nxt;
  logic cs_n_r, cs_n_nxt;
  logic mosi_r, mosi_nxt;
  logic tick;
  logic take;

  // Half-period enable pulse from the divider
  assign tick = (div_r == 3'(`SPI_SCK_HALF_CYC - 1));
  assign tx_ready_o = (state_r == spi_link_pkg::H_IDLE) || (state_r == spi_link_pkg::H_WAIT);
  assign take = tx_ready_o && tx_valid_i;

  // Next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    div_nxt = tick ? 3'h0 : div_r + 3'h1;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rx_data_nxt = rx_data_r;
    rx_valid_nxt = 1'b0;
    last_nxt = last_r;
    sclk_nxt = sclk_r;
    cs_n_nxt = cs_n_r;
    mosi_nxt = mosi_r;
    case (state_r)
      spi_link_pkg::H_IDLE, spi_link_pkg::H_WAIT: begin
        div_nxt = 3'h0;
        if (take) begin
          // Select goes low and stays low for the message
          tx_nxt = tx_data_i;
          last_nxt = tx_last_i;
          cs_n_nxt = 1'b0;
          state_nxt = spi_link_pkg::H_LEAD;
        end
      end
      spi_link_pkg::H_LEAD, spi_link_pkg::H_LOW: begin
        if (tick) begin
          if (state_r == spi_link_pkg::H_LEAD || bit_r != 3'h0) begin
            // Rising edge: drive the next bit, top first
            sclk_nxt = 1'b1;
            mosi_nxt = tx_r[7];
            tx_nxt = spi_link_pkg::shift_up(tx_r, 1'b0);
            state_nxt = spi_link_pkg::H_HIGH;
          end else if (last_r) begin
            cs_n_nxt = 1'b1;
            state_nxt = spi_link_pkg::H_GAP;
          end else begin
            state_nxt = spi_link_pkg::H_WAIT;
          end
        end
      end
      spi_link_pkg::H_HIGH: begin
        if (tick) begin
          // Falling edge: sample the reader's bit
          sclk_nxt = 1'b0;
          rx_nxt = spi_link_pkg::shift_up(rx_r, link.miso);
          bit_nxt = bit_r + 3'h1;
          if (bit_r == `SPI_LAST_BIT) begin
            rx_data_nxt = spi_link_pkg::shift_up(rx_r, link.miso);
            rx_valid_nxt = 1'b1;
          end
          state_nxt = spi_link_pkg::H_LOW;
        end
      end
      spi_link_pkg::H_GAP: begin
        if (tick) begin
          state_nxt = spi_link_pkg::H_IDLE;
        end
      end
      default: state_nxt = spi_link_pkg::H_IDLE;
    endcase
  end

  // Register the sequencer
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= spi_link_pkg::H_IDLE;
      div_r <= 3'h0;
      bit_r <= 3'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
      last_r <= 1'b0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      mosi_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rx_data_r <= rx_data_nxt;
      rx_valid_r <= rx_valid_nxt;
      last_r <= last_nxt;
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      mosi_r <= mosi_nxt;
    end
  end

  // Pins and user outputs; boot line low asks for firmware update
  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = mosi_r;
  assign link.boot_sel_n = !boot_update_i;
  assign rx_data_o = rx_data_r;
  assign rx_valid_o = rx_valid_r;
  assign busy_o = (state_r != spi_link_pkg::H_IDLE);

endmodule : reader_spi_master

// [bench/spi_link_properties.sv]
// Concurrent checks on the wires between the two ends of the serial link
`timescale 1ns/100ps
module spi_link_properties (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic boot_sel_n,
  input wire logic dev_miso,
  input wire logic dev_miso_oe,
  input wire logic miso
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  logic sclk_d_r;
  logic [7:0] falls_r;
  logic [7:0] falls_nxt;

  // Count falling serial edges inside one select window
  always_comb begin
    falls_nxt = falls_r;
    if (cs_n)
      falls_nxt = 8'h00;
    else if (sclk_d_r && !sclk)
      falls_nxt = falls_r + 8'h01;
  end

  // Register the edge detector and the counter
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_d_r <= 1'b0;
      falls_r <= 8'h00;
    end else begin
      sclk_d_r <= sclk;
      falls_r <= falls_nxt;
    end
  end

  idle_clk_low_a:
    assert property (cs_n |-> !sclk) else $error("clock high while deselected");
  oe_follows_sel_a:
    assert property (dev_miso_oe == !cs_n) else $error("reader drive not tied to select");
  undriven_low_a:
    assert property (cs_n |-> !miso) else $error("data line not low while released");
  mosi_hold_a:
    assert property ($rose(sclk) |=> $stable(mosi) [*3]) else $error("host data moved in high phase");
  miso_hold_a:
    assert property ($fell(sclk) |-> $stable(dev_miso)) else $error("reader data moved at fall");
  clk_high_len_a:
    assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("clock high phase length");
  select_lead_a:
    assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk) else $error("select lead time");
  select_gap_a:
    assert property ($rose(cs_n) |-> cs_n [*4]) else $error("select gap too short");
  whole_bytes_a:
    assert property ($rose(cs_n) |-> falls_r[2:0] == 3'h0 && falls_r != 8'h00)
      else $error("frame not whole bytes");

  // Main scenarios reached
  cover property ($rose(cs_n));
  cover property ($fell(sclk) && miso);
  cover property (!boot_sel_n);
endmodule : spi_link_properties

// [bench/testbench.sv]
// Self-checking bench joining the host end and the reader end
`timescale 1ns/100ps
module testbench;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic tx_last_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic boot_update_i = 1'b0;
  logic cmd_ready_i = 1'b1;
  logic [7:0] rsp_data_i = 8'h00;
  logic rsp_valid_i = 1'b0;
  logic [7:0] rx_data_o, cmd_data_o;
  logic tx_ready_o, rx_valid_o, busy_o, cmd_first_o, cmd_valid_o;
  logic msg_end_o, rsp_ready_o, overrun_o, boot_update_o;
  int n_mismatch = 0;
  int compares = 0;
  int n_end = 0;
  int rsp_idx = 0;
  int rsp_cnt = 0;
  int nb = 0;
  logic [7:0] rsp_buf [4];
  logic [7:0] sh;
  logic [8:0] cmd_q [$];
  logic [7:0] rx_q [$];
  logic [7:0] wq [$];

  // System clock, 10 ns
  always #5 sys_clk_i = ~sys_clk_i;

  spi_link_if i_spi_link_if ();
  reader_spi_master i_reader_spi_master (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .link(i_spi_link_if), .tx_data_i(tx_data_i), .tx_last_i(tx_last_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .busy_o(busy_o), .boot_update_i(boot_update_i));
  reader_spi_slave i_reader_spi_slave (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .link(i_spi_link_if), .cmd_data_o(cmd_data_o), .cmd_first_o(cmd_first_o),
    .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i), .msg_end_o(msg_end_o),
    .rsp_data_i(rsp_data_i), .rsp_valid_i(rsp_valid_i), .rsp_ready_o(rsp_ready_o),
    .overrun_o(overrun_o), .boot_update_o(boot_update_o));
  spi_link_properties u_props (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .sclk(i_spi_link_if.sclk), .cs_n(i_spi_link_if.cs_n), .mosi(i_spi_link_if.mosi),
    .boot_sel_n(i_spi_link_if.boot_sel_n), .dev_miso(i_spi_link_if.dev_miso),
    .dev_miso_oe(i_spi_link_if.dev_miso_oe), .miso(i_spi_link_if.miso));

  // Collect user-side results and feed queued reply bytes
  always @(posedge sys_clk_i) begin
    if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
    if (cmd_valid_o === 1'b1 && cmd_ready_i) cmd_q.push_back({cmd_first_o, cmd_data_o});
    if (msg_end_o === 1'b1) n_end++;
    if (rsp_ready_o === 1'b1 && rsp_valid_i) rsp_idx <= rsp_idx + 1;
    rsp_valid_i <= (rsp_idx < rsp_cnt) && !(rsp_ready_o === 1'b1 && rsp_valid_i);
    rsp_data_i <= rsp_buf[rsp_idx];
  end

  // Capture host data bits on the wire at each falling serial edge
  always @(negedge i_spi_link_if.sclk) if (i_spi_link_if.cs_n === 1'b0) begin
    sh = {sh[6:0], i_spi_link_if.mosi};
    nb++;
    if (nb == 8) begin
      wq.push_back(sh);
      nb = 0;
    end
  end
  always @(posedge i_spi_link_if.cs_n) nb = 0;

  task chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task hang;
    n_mismatch++;
    $display("MISMATCH wait expected done seen timeout");
    report_and_stop();
  endtask : hang

  task do_reset(input logic boot);
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    boot_update_i <= boot;
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
  endtask : do_reset

  // Offer one byte and hold it until the host end takes it
  task send(input logic [7:0] b, input logic last);
    int k;
    @(posedge sys_clk_i);
    tx_data_i <= b;
    tx_last_i <= last;
    tx_valid_i <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(negedge sys_clk_i);
      if (tx_ready_o === 1'b1) break;
    end
    if (k == 200) hang();
    @(posedge sys_clk_i);
    tx_valid_i <= 1'b0;
  endtask : send

  task wait_idle;
    int k;
    for (k = 0; k < 400; k++) begin
      @(negedge sys_clk_i);
      if (busy_o === 1'b0) break;
    end
    if (k == 400) hang();
    repeat (4) @(negedge sys_clk_i);
  endtask : wait_idle

  task clear_q;
    cmd_q.delete();
    rx_q.delete();
    wq.delete();
    n_end = 0;
  endtask : clear_q

  task test_idle;
    @(negedge sys_clk_i);
    chk("idle clock", 9'h000, {8'h00, i_spi_link_if.sclk});
    chk("idle select", 9'h001, {8'h00, i_spi_link_if.cs_n});
    chk("boot flag", 9'h000, {8'h00, boot_update_o});
    $display("test idle done");
  endtask : test_idle

  // Three-byte command, reply bytes queued by the bench for the reader
  task test_message;
    logic [7:0] tx_b [3];
    logic [7:0] rs_b [3];
    tx_b = '{8'h42, 8'hBE, 8'hEF};
    rs_b = '{8'hA5, 8'h3C, 8'h81};
    clear_q();
    for (int i = 0; i < 3; i++) rsp_buf[i] = rs_b[i];
    rsp_cnt = 3;
    for (int i = 0; i < 3; i++) send(tx_b[i], i == 2);
    wait_idle();
    chk("command count", 9'h003, 9'(cmd_q.size()));
    for (int i = 0; i < 3; i++) begin
      chk("command byte", {i == 0, tx_b[i]}, cmd_q[i]);
      chk("wire byte", {1'b0, tx_b[i]}, {1'b0, wq[i]});
      chk("reply byte", {1'b0, rs_b[i]}, {1'b0, rx_q[i]});
    end
    chk("field top byte", 9'h0BE, cmd_q[1]);
    chk("message ends", 9'h001, 9'(n_end));
    $display("test message done");
  endtask : test_message

  // Command with nothing to answer gets fill bytes
  task test_no_reply;
    clear_q();
    rsp_cnt = 0;
    send(8'h81, 1'b0);
    send(8'h7E, 1'b1);
    wait_idle();
    chk("fill byte", 9'h000, {1'b0, rx_q[0]});
    chk("fill byte", 9'h000, {1'b0, rx_q[1]});
    chk("command kept", 9'h07E, cmd_q[1]);
    $display("test no reply done");
  endtask : test_no_reply

  // Stalled consumer: buffer fills, third byte lost, flag clears later
  task test_overrun;
    clear_q();
    @(posedge sys_clk_i);
    cmd_ready_i <= 1'b0;
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b1);
    wait_idle();
    chk("overrun set", 9'h001, {8'h00, overrun_o});
    @(posedge sys_clk_i);
    cmd_ready_i <= 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk("kept count", 9'h002, 9'(cmd_q.size()));
    chk("kept head", 9'h111, cmd_q[0]);
    chk("kept second", 9'h022, cmd_q[1]);
    chk("drained", 9'h000, {8'h00, cmd_valid_o});
    send(8'h44, 1'b1);
    wait_idle();
    chk("overrun clear", 9'h000, {8'h00, overrun_o});
    chk("next head", 9'h144, cmd_q[2]);
    $display("test overrun done");
  endtask : test_overrun

  // Reset with the update strap held selects update mode
  task test_boot;
    do_reset(1'b1);
    @(negedge sys_clk_i);
    chk("strap line", 9'h000, {8'h00, i_spi_link_if.boot_sel_n});
    chk("boot flag", 9'h001, {8'h00, boot_update_o});
    $display("test boot done");
  endtask : test_boot

  initial begin
    do_reset(1'b0);
    test_idle();
    test_message();
    test_no_reply();
    test_overrun();
    test_boot();
    report_and_stop();
  end
endmodule : testbench
